/* File: common/pcx_pkg.sv */
/*
  constants for the counter array channel block: register map, field
  positions, reset values, timebase codes and mode encodings.
  assumes an apb slave with 32-bit data and byte addresses.
*/
// Contract
// - frequency mode period is twice high byte
// - low match toggles pin, adds high byte
// - compare, toggle, pwm enables select frequency mode
// - frequency mode flag on full 16-bit match
// - one shared cycle length for pwm
// - pwm8 pin high on low-byte match
// - pwm8 pin low on low-byte overflow
// - pwm8 reloads low byte from high
// - pwm8 when pwm set, toggle clear, select 00b
// - pwm8 match sets channel flag
// - pwm8 overflow sets cycle overflow flag
// - low write clears, high write sets compare
// - pwm8 duty is 256 minus high byte
// - compare cleared holds pwm8 output low
// - idle suspend bit stops counter in idle
// - three-bit field selects counter timebase
// - bit zero gates overflow interrupt request
// - mode bits 6:4 read zero, ignored
package pcx_pkg;
  localparam int NCH = 2;
  localparam logic [11:0] ADDR_MODE = 12'h0D9 << 2;
  localparam logic [11:0] ADDR_CNT = 12'h100;
  localparam logic [11:0] ADDR_PWMCFG = 12'h104;
  localparam logic [11:0] ADDR_STAT = 12'h108;
  localparam logic [11:0] ADDR_CH_BASE = 12'h110;
  localparam logic [11:0] CH_STRIDE = 12'h010;
  localparam logic [3:0] CH_CPM = 4'h0;
  localparam logic [3:0] CH_CPL = 4'h4;
  localparam logic [3:0] CH_CPH = 4'h8;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'h8F;
  localparam int MODE_IDLE = 7;
  localparam int MODE_IRQ = 0;
  localparam int CPM_ECOM = 6;
  localparam int CPM_MAT = 3;
  localparam int CPM_TOG = 2;
  localparam int CPM_PWM = 1;
  localparam int CPM_CCF = 7;
  localparam logic [7:0] CPM_WMASK = 8'h4E;
  localparam logic [1:0] CYCLE_LENGTH_SELECT_8 = 2'h0;
  localparam int PWMCFG_CYCLE_OVERFLOW_FLAG = 7;
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4 = 3'h1;
  localparam logic [2:0] TB_T0 = 3'h2;
  localparam logic [2:0] TB_ECI = 3'h3;
  localparam logic [2:0] TB_SYS = 3'h4;
  localparam logic [2:0] TB_EXT8 = 3'h5;
  localparam logic [2:0] TB_T4 = 3'h6;
  localparam logic [2:0] TB_T5 = 3'h7;
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  typedef enum logic [1:0] {
    PCX_OFF = 2'b00,
    PCX_FREQ = 2'b01,
    PCX_PWM8 = 2'b10
  } pcx_mode_t;
endpackage

/* File: design/pcx_top.sv */
/*
  counter array with two channels: frequency output and 8-bit pwm,
  plus the array mode register with timebase select and idle suspend.
  assumes apb master on clk; tick inputs are one-cycle pulses on clk.
*/
`timescale 1ns/10ps
`default_nettype none
module pcx_top
  import pcx_pkg::*;
(
  input wire logic clk, // 50 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic cpu_idle, // processor in idle
  input wire logic timer0_ovf, // timer 0 overflow pulse
  input wire logic timer4_ovf, // timer 4 overflow pulse
  input wire logic timer5_ovf, // timer 5 overflow pulse
  input wire logic external_count_input, // external count level
  input wire logic ext_clk_tick, // synchronised external clock pulse
  output logic [pcx_pkg::NCH-1:0] channel_wave_pin, // waveform pins
  output logic overflow_irq // overflow interrupt request
);
  typedef struct packed {
    logic [7:0] mode;
    logic [15:0] cnt;
    logic cf;
    logic [1:0] cycle_length_select;
    logic cycle_overflow_flag;
    logic [NCH-1:0][7:0] cpm;
    logic [NCH-1:0][7:0] cpl;
    logic [NCH-1:0][7:0] cph;
    logic [NCH-1:0] wave;
    logic [3:0] div12;
    logic [1:0] div4;
    logic [2:0] div8;
    logic eci_d;
    logic [31:0] rdata;
    logic err;
  } pcx_state_t;

  pcx_state_t s_r, s_nxt;
  logic tick, wr, rd, ovf8, hit;
  logic [15:0] cnt_inc;
  logic [11:0] coff;
  logic [1:0] ch_idx;
  logic [NCH-1:0][1:0] md;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = psel && penable;
  assign prdata = s_r.rdata;
  assign pslverr = s_r.err && pready;
  assign channel_wave_pin = s_r.wave;
  // request follows the flag as long as the enable is set
  assign overflow_irq = s_r.cf && s_r.mode[MODE_IRQ];
  assign cnt_inc = s_r.cnt + 16'h0001;
  assign ovf8 = tick && (s_r.cnt[7:0] == 8'hFF);

  // channel decode: stride of 16 bytes from channel base
  assign coff = paddr - ADDR_CH_BASE;
  assign ch_idx = coff[5:4];
  assign hit = (paddr >= ADDR_CH_BASE) && (coff[11:4] < 8'(NCH));

  // timebase pick, counter stops in idle if asked
  always_comb
  begin
    unique case (s_r.mode[3:1])
      TB_DIV12: tick = (s_r.div12 == DIV12_LAST);
      TB_DIV4: tick = (s_r.div4 == DIV4_LAST);
      TB_T0: tick = timer0_ovf;
      TB_ECI: tick = s_r.eci_d && !external_count_input;
      TB_SYS: tick = 1'b1;
      TB_EXT8: tick = ext_clk_tick && (s_r.div8 == DIV8_LAST);
      TB_T4: tick = timer4_ovf;
      TB_T5: tick = timer5_ovf;
    endcase
    if (s_r.mode[MODE_IDLE] && cpu_idle)
    begin
      tick = 1'b0;
    end
  end

  // one mode per channel; pwm8 needs the shared cycle length at 00b
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_md
      always_comb
      begin
        if (s_r.cpm[g][CPM_ECOM] && s_r.cpm[g][CPM_TOG] &&
            s_r.cpm[g][CPM_PWM])
        begin
          md[g] = PCX_FREQ;
        end
        else if (s_r.cpm[g][CPM_PWM] && !s_r.cpm[g][CPM_TOG] &&
                 s_r.cycle_length_select == CYCLE_LENGTH_SELECT_8)
        begin
          // compare cleared still counts as pwm8 so the pin parks low
          md[g] = PCX_PWM8;
        end
        else
        begin
          md[g] = PCX_OFF;
        end
      end
    end
  endgenerate

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.err = 1'b0;
    s_nxt.eci_d = external_count_input;
    s_nxt.div12 = (s_r.div12 == DIV12_LAST) ? 4'h0 : s_r.div12 + 4'h1;
    s_nxt.div4 = s_r.div4 + 2'h1;
    if (ext_clk_tick)
    begin
      s_nxt.div8 = s_r.div8 + 3'h1;
    end
    if (tick)
    begin
      s_nxt.cnt = cnt_inc;
      if (s_r.cnt == 16'hFFFF)
      begin
        s_nxt.cf = 1'b1;
      end
    end
    for (int i = 0; i < NCH; i++)
    begin
      if (md[i] == PCX_FREQ && tick &&
          s_r.cpl[i] == s_r.cnt[7:0])
      begin
        // each half period is cph counts, 0 wraps to 256
        s_nxt.wave[i] = !s_r.wave[i];
        s_nxt.cpl[i] = s_r.cpl[i] + s_r.cph[i];
      end
      if (md[i] == PCX_FREQ && tick && s_r.cpm[i][CPM_MAT] &&
          s_r.cnt == {s_r.cph[i], s_r.cpl[i]})
      begin
        s_nxt.cpm[i][CPM_CCF] = 1'b1;
      end
      if (md[i] == PCX_PWM8)
      begin
        if (!s_r.cpm[i][CPM_ECOM])
        begin
          s_nxt.wave[i] = 1'b0;
        end
        else if (ovf8)
        begin
          // a reload of zero matches the new count at once: full duty
          s_nxt.wave[i] = (s_r.cph[i] == 8'h00);
        end
        else if (tick && cnt_inc[7:0] == s_r.cpl[i] && !s_r.wave[i])
        begin
          // high from match to wrap gives (256-cph)/256 duty
          s_nxt.wave[i] = 1'b1;
          if (s_r.cpm[i][CPM_MAT])
          begin
            s_nxt.cpm[i][CPM_CCF] = 1'b1;
          end
        end
        if (ovf8)
        begin
          s_nxt.cpl[i] = s_r.cph[i];
        end
      end
      if (md[i] == PCX_OFF)
      begin
        s_nxt.wave[i] = 1'b0;
      end
    end
    // software writes; hardware sets below win over clears
    if (wr)
    begin
      if (paddr == ADDR_MODE)
      begin
        s_nxt.mode = pwdata[7:0] & MODE_WMASK;
      end
      else if (paddr == ADDR_CNT)
      begin
        s_nxt.cnt = pwdata[15:0];
      end
      else if (paddr == ADDR_PWMCFG)
      begin
        s_nxt.cycle_length_select = pwdata[1:0];
        s_nxt.cycle_overflow_flag = s_r.cycle_overflow_flag && pwdata[PWMCFG_CYCLE_OVERFLOW_FLAG];
      end
      else if (paddr == ADDR_STAT)
      begin
        s_nxt.cf = s_r.cf && pwdata[0];
      end
      else if (hit)
      begin
        unique case (coff[3:0])
          CH_CPM:
          begin
            s_nxt.cpm[ch_idx] = (pwdata[7:0] & CPM_WMASK) |
              {s_r.cpm[ch_idx][CPM_CCF] && pwdata[CPM_CCF], 7'h00};
          end
          CH_CPL:
          begin
            s_nxt.cpl[ch_idx] = pwdata[7:0];
            s_nxt.cpm[ch_idx][CPM_ECOM] = 1'b0;
          end
          CH_CPH:
          begin
            s_nxt.cph[ch_idx] = pwdata[7:0];
            s_nxt.cpm[ch_idx][CPM_ECOM] = 1'b1;
          end
          default: s_nxt.err = 1'b1;
        endcase
      end
      else
      begin
        s_nxt.err = 1'b1;
      end
    end
    if (tick && s_r.cnt == 16'hFFFF)
    begin
      s_nxt.cf = 1'b1;
    end
    if (ovf8)
    begin
      s_nxt.cycle_overflow_flag = 1'b1;
    end
    for (int i = 0; i < NCH; i++)
    begin
      if (s_nxt.wave[i] && !s_r.wave[i] && md[i] == PCX_PWM8 &&
          s_r.cpm[i][CPM_MAT])
      begin
        s_nxt.cpm[i][CPM_CCF] = 1'b1;
      end
    end
    // read data and error registered in the setup cycle, ready at access
    s_nxt.rdata = 32'h0000_0000;
    if (psel && !penable)
    begin
      if (paddr == ADDR_MODE)
      begin
        s_nxt.rdata = {24'h000000, s_r.mode & MODE_WMASK};
      end
      else if (paddr == ADDR_CNT)
      begin
        s_nxt.rdata = {16'h0000, s_r.cnt};
      end
      else if (paddr == ADDR_PWMCFG)
      begin
        s_nxt.rdata = {24'h000000, s_r.cycle_overflow_flag, 5'h00, s_r.cycle_length_select};
      end
      else if (paddr == ADDR_STAT)
      begin
        s_nxt.rdata = {31'h00000000, s_r.cf};
      end
      else if (hit)
      begin
        unique case (coff[3:0])
          CH_CPM: s_nxt.rdata = {24'h000000, s_r.cpm[ch_idx]};
          CH_CPL: s_nxt.rdata = {24'h000000, s_r.cpl[ch_idx]};
          CH_CPH: s_nxt.rdata = {24'h000000, s_r.cph[ch_idx]};
          default: s_nxt.err = 1'b1;
        endcase
      end
      else
      begin
        s_nxt.err = 1'b1;
      end
    end
    else if (rd)
    begin
      s_nxt.rdata = s_r.rdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  irq_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    overflow_irq == (s_r.cf && s_r.mode[MODE_IRQ]))
    else $error("overflow request not gated by enable");
  mode_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    s_r.mode[6:4] == 3'b000)
    else $error("unused mode bits not zero");
  cnt_wrap_a: assert property (@(posedge clk) disable iff (!arst_n)
    (tick && s_r.cnt == 16'hFFFF && !wr) |=> s_r.cf)
    else $error("overflow flag not set on wrap");
  idle_stop_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s_r.mode[MODE_IDLE] && cpu_idle && !wr) |=> $stable(s_r.cnt))
    else $error("counter ran during idle suspend");
  cycle_overflow_flag_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    ovf8 |=> s_r.cycle_overflow_flag)
    else $error("cycle overflow flag missed");
  pwm_low_a: assert property (@(posedge clk) disable iff (!arst_n)
    (md[0] == PCX_PWM8 && ovf8 && s_r.cph[0] != 8'h00)
    |=> !channel_wave_pin[0])
    else $error("pwm output not low after overflow");
  pwm_reload_a: assert property (@(posedge clk) disable iff (!arst_n)
    (md[0] == PCX_PWM8 && ovf8 && !wr) |=> s_r.cpl[0] == $past(s_r.cph[0]))
    else $error("low byte not reloaded");
  zero_duty_a: assert property (@(posedge clk) disable iff (!arst_n)
    (md[0] == PCX_PWM8 && !s_r.cpm[0][CPM_ECOM]) |=> !s_r.wave[0])
    else $error("output not held low with compare off");
  freq_tog_a: assert property (@(posedge clk) disable iff (!arst_n)
    (md[0] == PCX_FREQ && tick && s_r.cpl[0] == s_r.cnt[7:0])
    |=> s_r.wave[0] != $past(s_r.wave[0]))
    else $error("frequency output did not toggle");
endmodule
`default_nettype wire

/* File: verif/pcx_top_bench.sv */
/*
  self-checking bench for the two-channel counter array block.
  assumes zero-wait apb answers and the sysclk timebase ticking each clk.
*/
`timescale 1ns/10ps
`default_nettype none
module pcx_top_bench;
  import pcx_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, cpu_idle = 1'b0, clr = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, a;
  logic pready, pslverr, overflow_irq;
  logic [NCH-1:0] pin;
  logic [15:0] hi0, rs0, hi1, rs1;
  logic [7:0] duty [3] = '{8'h00, 8'h40, 8'hFF};
  int n_errors = 0, n_compared = 0;
  always #10 clk = ~clk;
  pcx_top u_dut (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_idle(cpu_idle), .timer0_ovf(1'b0), .timer4_ovf(1'b0),
    .timer5_ovf(1'b0), .external_count_input(1'b0), .ext_clk_tick(1'b0),
    .channel_wave_pin(pin), .overflow_irq(overflow_irq));
  pcx_wave_watch u_w0 (.clk(clk), .clr(clr), .pin(pin[0]),
    .high_cnt(hi0), .rise_cnt(rs0));
  pcx_wave_watch u_w1 (.clk(clk), .clr(clr), .pin(pin[1]),
    .high_cnt(hi1), .rise_cnt(rs1));
  task final_report;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one transfer; returns at the edge where pready was sampled
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1)
    begin
      n_errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] cha(input int n, input logic [3:0] o);
    return ADDR_CH_BASE + CH_STRIDE * n[11:0] + {8'h00, o};
  endfunction
  // exactly 512 samples after the clear, a whole number of periods
  task count;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (513) @(posedge clk);
  endtask
  task t_regs;
    apb(1'b0, ADDR_MODE, 32'h0);
    chk("mode reset", 32'h0, rd);
    apb(1'b1, ADDR_MODE, 32'hFF);
    apb(1'b0, ADDR_MODE, 32'h0);
    chk("mode unused bits", 32'h8F, rd);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, cha(0, CH_CPM), 32'h42);
    apb(1'b1, cha(0, CH_CPL), 32'h0);
    apb(1'b0, cha(0, CH_CPM), 32'h0);
    chk("low write", 32'h0, {31'h0, rd[6]});
    apb(1'b1, cha(0, CH_CPH), 32'h0);
    apb(1'b0, cha(0, CH_CPM), 32'h0);
    chk("high write", 32'h1, {31'h0, rd[6]});
  endtask
  task t_wave;
    apb(1'b1, ADDR_MODE, 32'h08);
    apb(1'b1, ADDR_PWMCFG, 32'h0);
    apb(1'b1, cha(1, CH_CPM), 32'h46);
    apb(1'b1, cha(1, CH_CPL), 32'h0);
    apb(1'b1, cha(1, CH_CPH), 32'h08);
    apb(1'b1, cha(0, CH_CPM), 32'h4A);
    for (int j = 0; j < 3; j++)
    begin
      apb(1'b1, cha(0, CH_CPL), {24'h0, duty[j]});
      apb(1'b1, cha(0, CH_CPH), {24'h0, duty[j]});
      repeat (300) @(posedge clk);
      count();
      chk("pwm high", 32'd512 - 32'd2 * duty[j], {16'h0, hi0});
      chk("freq high", 32'd256, {16'h0, hi1});
      chk("freq rises", 32'd32, {16'h0, rs1});
      if (j == 1)
        chk("pwm rises", 32'd2, {16'h0, rs0});
    end
    apb(1'b0, ADDR_PWMCFG, 32'h0);
    chk("cycle ovf", 32'h1, {31'h0, rd[7]});
    apb(1'b0, cha(0, CH_CPM), 32'h0);
    chk("match flag", 32'h1, {31'h0, rd[7]});
    apb(1'b1, cha(0, CH_CPL), 32'h80);
    repeat (300) @(posedge clk);
    count();
    chk("zero duty", 32'h0, {16'h0, hi0});
    chk("freq alone", 32'd32, {16'h0, rs1});
  endtask
  task t_irq;
    apb(1'b1, ADDR_MODE, 32'h09);
    apb(1'b1, ADDR_STAT, 32'h0);
    apb(1'b1, ADDR_CNT, 32'hFFF0);
    repeat (40) @(posedge clk);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("wrap flag", 32'h1, {31'h0, rd[0]});
    chk("irq on", 32'h1, {31'h0, overflow_irq});
    apb(1'b1, ADDR_MODE, 32'h08);
    @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, overflow_irq});
  endtask
  task t_idle;
    apb(1'b1, ADDR_MODE, 32'h88);
    cpu_idle <= 1'b1;
    apb(1'b0, ADDR_CNT, 32'h0);
    a = rd;
    apb(1'b0, ADDR_CNT, 32'h0);
    chk("idle hold", a, rd);
    apb(1'b1, ADDR_MODE, 32'h08);
    apb(1'b0, ADDR_CNT, 32'h0);
    a = rd;
    apb(1'b0, ADDR_CNT, 32'h0);
    chk("idle run", 32'h1, {31'h0, rd !== a});
    cpu_idle <= 1'b0;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_wave();
    t_irq();
    t_idle();
    final_report();
  end
endmodule
`default_nettype wire

/* File: verif/pcx_wave_watch.sv */
/*
  far-side watcher on one waveform pin: counts high cycles and rises.
  assumes the pin is driven by the block on every clk cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module pcx_wave_watch (
  input wire logic clk, // sample clock
  input wire logic clr, // restart the counts
  input wire logic pin, // watched waveform pin
  output logic [15:0] high_cnt, // cycles seen high
  output logic [15:0] rise_cnt // low to high edges
);
  logic prev_r;
  always_ff @(posedge clk)
  begin
    prev_r <= pin;
    if (clr)
    begin
      high_cnt <= 16'h0000;
      rise_cnt <= 16'h0000;
    end
    else
    begin
      high_cnt <= high_cnt + {15'h0000, pin};
      rise_cnt <= rise_cnt + {15'h0000, pin & ~prev_r};
    end
  end
endmodule
`default_nettype wire
